// ==== hdl/arr_params.svh ====
// constants for the converter result register bank
`ifndef ARR_PARAMS_SVH
`define ARR_PARAMS_SVH
`define ARR_OFS_IIN_HI 8'h17
`define ARR_OFS_IIN_LO 8'h18
`define ARR_OFS_ICHG_HI 8'h19
`define ARR_OFS_ICHG_LO 8'h1a
`define ARR_OFS_VIN_HI 8'h1b
`define ARR_OFS_VIN_LO 8'h1c
`define ARR_RESET_BYTE 8'h00
`define ARR_RESET_WORD 16'h0000
`define ARR_ICHG_RSVD_MASK 8'h7f
`define ARR_SIGN_BIT 15
`endif

// ==== hdl/arr_pkg.sv ====
// types for the converter result register bank
package arr_pkg;
  typedef enum logic [2:0] {
    ARR_IDLE = 3'b001,
    ARR_CONT = 3'b010,
    ARR_DONE = 3'b100
  } arr_state_t;
  typedef logic [15:0] arr_word_t;
endpackage

// ==== hdl/arr_res_if.sv ====
// result words passed from the main module to the read mux
`timescale 1ns/1ps
interface arr_res_if;
  logic [15:0] iin;  // input current result
  logic [15:0] ichg; // charge current result
  logic [15:0] vin;  // input voltage result
  modport src (output iin, output ichg, output vin);
  modport dst (input iin, input ichg, input vin);
endinterface

// ==== hdl/arr_rd_mux.sv ====
// read-side decode of the result register bytes
`timescale 1ns/1ps
`include "arr_params.svh"
module arr_rd_mux
  import arr_pkg::*;
(
  arr_res_if.dst res,
  input wire logic [7:0] addr,
  output logic [7:0] data,
  output logic hit
);
  // bit 7 of the charge high byte is reserved and masked to zero
  wire [7:0] ichg_hi = res.ichg[15:8] & `ARR_ICHG_RSVD_MASK;
  always_comb begin
    hit = 1'b1;
    case (addr)
      `ARR_OFS_IIN_HI: data = res.iin[15:8];
      `ARR_OFS_IIN_LO: data = res.iin[7:0];
      `ARR_OFS_ICHG_HI: data = ichg_hi;
      `ARR_OFS_ICHG_LO: data = res.ichg[7:0];
      `ARR_OFS_VIN_HI: data = res.vin[15:8];
      `ARR_OFS_VIN_LO: data = res.vin[7:0];
      default: begin
        data = `ARR_RESET_BYTE;
        hit = 1'b0;
      end
    endcase
  end
endmodule

// ==== hdl/arr_result_regs.sv ====
// converter result register bank, read-only bytes behind the host port
`timescale 1ns/1ps
`include "arr_params.svh"
module arr_result_regs
  import arr_pkg::*;
(
  clk,
  sys_rst,
  clk_en,
  reg_rst,
  wdog_expire,
  conv_en,
  conv_rate,
  conv_start,
  sample_valid,
  sample_iin,
  sample_ichg,
  sample_vin,
  rd_en,
  wr_en,
  addr,
  wdata,
  rdata,
  rd_hit,
  conv_busy
);
  input wire logic clk;
  input wire logic sys_rst;            // synchronous, active high
  input wire logic clk_en;             // low freezes all state; resets still clear
  input wire logic reg_rst;            // register-default reset
  input wire logic wdog_expire;        // watchdog expiry, no effect here
  input wire logic conv_en;            // converter enable bit
  input wire logic conv_rate;          // 0 continuous, 1 one-shot
  input wire logic conv_start;         // one-shot request pulse
  input wire logic sample_valid;       // converter has a fresh sample
  input wire logic [15:0] sample_iin;  // signed, into pin positive
  input wire logic [15:0] sample_ichg;
  input wire logic [15:0] sample_vin;  // two's complement
  input wire logic rd_en;              // host read strobe
  input wire logic wr_en;              // host write strobe, ignored
  input wire logic [7:0] addr;
  input wire logic [7:0] wdata;        // ignored, bank is read-only
  output logic [7:0] rdata;
  output logic rd_hit;
  output logic conv_busy;              // one-shot pending

  arr_res_if res ();                   // result words to the read mux
  arr_word_t iin_r, ichg_r, vin_r;     // stored results
  arr_state_t st_r, st_nxt;            // refresh sequencer
  logic [7:0] rdata_r, mux_data;
  logic rd_hit_r, mux_hit, busy_r;
  logic clr;                           // any clearing reset
  logic take;                          // capture this sample

  assign clr = sys_rst | reg_rst;
  // watchdog and writes never reach the result storage
  assign take = conv_en && sample_valid &&
                (st_r == ARR_CONT);
  assign res.iin = iin_r;
  assign res.ichg = ichg_r;
  assign res.vin = vin_r;

  // sequencer: continuous mode stays in CONT, one-shot waits for start
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ARR_IDLE: begin
        if (conv_en && (!conv_rate || conv_start))
          st_nxt = ARR_CONT;
      end
      ARR_CONT: begin
        if (!conv_en)
          st_nxt = ARR_IDLE;
        else if (sample_valid && conv_rate)
          st_nxt = ARR_DONE;
      end
      ARR_DONE: st_nxt = ARR_IDLE;
      default: st_nxt = ARR_IDLE;
    endcase
  end

  // result capture; stale values hold while disabled
  always_ff @(posedge clk) begin
    if (clr) begin
      iin_r <= `ARR_RESET_WORD;
      ichg_r <= `ARR_RESET_WORD;
      vin_r <= `ARR_RESET_WORD;
      st_r <= ARR_IDLE;
    end else if (clk_en) begin
      st_r <= st_nxt;
      if (take) begin
        iin_r <= sample_iin;
        ichg_r <= sample_ichg;
        vin_r <= sample_vin;
      end
    end
  end

  arr_rd_mux u_mux (
    .res(res.dst),
    .addr(addr),
    .data(mux_data),
    .hit(mux_hit)
  );

  // registered read answer, one cycle after the strobe
  always_ff @(posedge clk) begin
    if (clr) begin
      rdata_r <= `ARR_RESET_BYTE;
      rd_hit_r <= 1'b0;
      busy_r <= 1'b0;
    end else if (clk_en) begin
      busy_r <= (st_nxt == ARR_CONT) && conv_rate;
      if (rd_en) begin
        rdata_r <= mux_data;
        rd_hit_r <= mux_hit;
      end
    end
  end
  assign rdata = rdata_r;
  assign rd_hit = rd_hit_r;
  assign conv_busy = busy_r;

  chk_rst_clears: assert property (@(posedge clk)
    $past(reg_rst) |-> (iin_r == `ARR_RESET_WORD &&
    vin_r == `ARR_RESET_WORD && ichg_r == `ARR_RESET_WORD))
    else $error("reset did not clear results");
  chk_dis_holds: assert property (@(posedge clk) disable iff (clr)
    (!conv_en && clk_en) |=> $stable(vin_r))
    else $error("result changed while disabled");
  // a low clock enable must freeze the stored current words
  chk_freeze_holds: assert property (@(posedge clk) disable iff (clr)
    !clk_en |=> ($stable(iin_r) && $stable(ichg_r)))
    else $error("result changed while frozen");
  chk_rsvd_zero: assert property (@(posedge clk) disable iff (clr)
    (rd_en && clk_en && addr == `ARR_OFS_ICHG_HI) |=> !rdata[7])
    else $error("reserved bit read as one");
  chk_lo_iin: assert property (@(posedge clk) disable iff (clr)
    (rd_en && clk_en && addr == `ARR_OFS_IIN_LO) |=>
    rdata == $past(iin_r[7:0]))
    else $error("input current low byte wrong");
  chk_hi_vin: assert property (@(posedge clk) disable iff (clr)
    (rd_en && clk_en && addr == `ARR_OFS_VIN_HI) |=>
    rdata == $past(vin_r[15:8]))
    else $error("voltage high byte wrong");
  chk_lo_vin: assert property (@(posedge clk) disable iff (clr)
    (rd_en && clk_en && addr == `ARR_OFS_VIN_LO) |=>
    rdata == $past(vin_r[7:0]))
    else $error("voltage low byte wrong");
  chk_hi_iin: assert property (@(posedge clk) disable iff (clr)
    (rd_en && clk_en && addr == `ARR_OFS_IIN_HI) |=>
    rdata == $past(iin_r[15:8]))
    else $error("input current high byte wrong");
  chk_lo_ichg: assert property (@(posedge clk) disable iff (clr)
    (rd_en && clk_en && addr == `ARR_OFS_ICHG_LO) |=>
    rdata == $past(ichg_r[7:0]))
    else $error("charge low byte wrong");
  chk_capture: assert property (@(posedge clk) disable iff (clr)
    (take && clk_en) |=> iin_r == $past(sample_iin))
    else $error("sample not captured");
  chk_sign_kept: assert property (@(posedge clk) disable iff (clr)
    (take && clk_en) |=> vin_r[15] == $past(sample_vin[15]))
    else $error("voltage sign lost");
endmodule

// ==== sim/arr_host_model.sv ====
// host processor model issuing byte reads
`timescale 1ns/1ps
module arr_host_model (
  input wire logic clk,
  output logic rd_en,
  output logic [7:0] addr
);
  initial begin
    rd_en = 1'b0;
    addr = 8'h00;
  end
  // one-cycle strobe; data is valid once the strobe drops
  task automatic rd(input logic [7:0] a);
    rd_en = 1'b1;
    addr = a;
    @(posedge clk);
    #1 rd_en = 1'b0;
    addr = ~a; // released bus shows a changing pattern
  endtask
endmodule

// ==== sim/arr_result_regs_tb_top.sv ====
// self-checking bench for the result register bank
`timescale 1ns/1ps
module arr_result_regs_tb_top;
  import arr_pkg::*;
  logic clk = 0, sys_rst = 1, reg_rst = 0, wdog = 0, en = 0, rate = 0;
  logic start = 0, sv = 0, wr_en = 0, rd_en, rd_hit, busy, ce = 1;
  logic [7:0] addr, rdata;
  arr_word_t s_i = 0, s_c = 0, s_v = 0;
  int bad_count = 0, n_tests = 0, cyc = 0;
  always #5 clk = ~clk;
  arr_host_model host (.clk(clk), .rd_en(rd_en), .addr(addr));
  arr_result_regs dut (.clk(clk), .sys_rst(sys_rst), .clk_en(ce),
    .reg_rst(reg_rst), .wdog_expire(wdog), .conv_en(en), .conv_rate(rate),
    .conv_start(start), .sample_valid(sv), .sample_iin(s_i),
    .sample_ichg(s_c), .sample_vin(s_v), .rd_en(rd_en), .wr_en(wr_en),
    .addr(addr), .wdata(8'hff), .rdata(rdata), .rd_hit(rd_hit),
    .conv_busy(busy));
  task automatic cmp(input string nm, input logic [7:0] e, g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one read, then an idle edge so the strobe never rises twice at once
  task automatic chk(input logic [7:0] a, e, input logic h);
    host.rd(a);
    cmp("rdata", e, rdata);
    cmp("rd_hit", {7'h00, h}, {7'h00, rd_hit});
    @(posedge clk);
    #1;
  endtask
  task automatic chk_all(input arr_word_t i, c, v);
    chk(8'h17, i[15:8], 1);
    chk(8'h18, i[7:0], 1);
    chk(8'h19, {1'b0, c[14:8]}, 1);
    chk(8'h1a, c[7:0], 1);
    chk(8'h1b, v[15:8], 1);
    chk(8'h1c, v[7:0], 1);
  endtask
  // converter side: one valid pulse carrying all three words
  task automatic smp(input arr_word_t i, c, v);
    s_i = i;
    s_c = c;
    s_v = v;
    sv = 1;
    @(posedge clk);
    #1 sv = 0;
  endtask
  task automatic t_reset;
    chk_all(0, 0, 0);
    chk(8'h16, 8'h00, 0);
    chk(8'h1d, 8'h00, 0);
  endtask
  // negative current and voltage, charge word with bit 15 set
  task automatic t_cont;
    en = 1;
    @(posedge clk);
    #1 smp(16'hff38, 16'h8fa5, 16'hfc18);
    chk_all(16'hff38, 16'h8fa5, 16'hfc18);
    en = 0;
    smp(16'h1234, 16'h5678, 16'h2710);
    chk_all(16'hff38, 16'h8fa5, 16'hfc18);
  endtask
  task automatic t_oneshot;
    en = 1;
    rate = 1;
    smp(16'h1234, 16'h5678, 16'h2710);
    chk_all(16'hff38, 16'h8fa5, 16'hfc18);
    start = 1;
    @(posedge clk);
    #1 start = 0;
    cmp("busy", 8'h01, {7'h00, busy});
    smp(16'h0fa0, 16'h0001, 16'h2710);
    cmp("busy", 8'h00, {7'h00, busy});
    chk_all(16'h0fa0, 16'h0001, 16'h2710);
  endtask
  // writes and watchdog keep data, default reset clears it
  task automatic t_keep;
    en = 0;
    wr_en = 1;
    wdog = 1;
    chk_all(16'h0fa0, 16'h0001, 16'h2710);
    wr_en = 0;
    wdog = 0;
    reg_rst = 1;
    @(posedge clk);
    #1 reg_rst = 0;
    chk_all(0, 0, 0);
  endtask
  // a sample offered while the clock enable is low must not land
  task automatic t_freeze;
    en = 1;
    rate = 0;
    @(posedge clk);
    #1 ce = 0;
    smp(16'h0bb8, 16'h03e8, 16'h1388);
    ce = 1;
    chk_all(0, 0, 0);
    en = 0;
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // hang guard, far above the about 115 cycles needed
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      bad_count++;
      report_and_stop();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    #1 sys_rst = 0;
    t_reset();
    t_cont();
    t_oneshot();
    t_keep();
    t_freeze();
    report_and_stop();
  end
endmodule
